// ---- logic/ssr_pkg.sv ----
// Shared constants and types for the synchronous serial receive/duplex block
package ssr_pkg;
  // ==========================================================================
  // Buffer geometry
  // ==========================================================================
  localparam int unsigned BUF_WORDS = 8;             // Data buffer words
  localparam int unsigned IDX_W     = 3;             // Buffer index width
  localparam int unsigned DATA_W    = 8;             // Buffer word width
  localparam int unsigned BIT_W     = 3;             // Bit counter width
  localparam logic [BIT_W-1:0] LAST_BIT_4 = 3'h3;    // Final bit index, 4-bit words
  localparam logic [BIT_W-1:0] LAST_BIT_8 = 3'h7;    // Final bit index, 8-bit words
  localparam logic [IDX_W-1:0] IDX_FIRST  = 3'h0;    // Lowest buffer word
  localparam logic [IDX_W-1:0] IDX_ONE    = 3'h1;    // Index step
  localparam logic [BIT_W-1:0] BIT_ONE    = 3'h1;    // Bit counter step
  localparam logic [DATA_W-1:0] WORD_ZERO = 8'h00;   // Cleared buffer word
  localparam logic [3:0]        NIBBLE_ZERO = 4'h0;  // Upper half of 4-bit words

  // ==========================================================================
  // Mode and clock selection
  // ==========================================================================
  localparam logic MODE_RX     = 1'b0;               // Receive only
  localparam logic MODE_DUPLEX = 1'b1;               // 8-bit transmit/receive
  localparam logic [2:0] RATE_EXT = 3'h7;            // Serial clock from pin

  // ==========================================================================
  // Internal serial clock timing (core clock 10 MHz)
  // ==========================================================================
  localparam int unsigned CORE_HZ = 10_000_000;      // Core clock rate
  localparam int unsigned CNT_W   = 12;              // Half period counter width
  // Serial clock period in ns per rate code, slowest first
  localparam int unsigned PERIOD_NS_0 = 409600;      // fc/2^12 equivalent
  localparam int unsigned PERIOD_NS_1 = 12800;
  localparam int unsigned PERIOD_NS_2 = 6400;
  localparam int unsigned PERIOD_NS_3 = 3200;
  localparam int unsigned PERIOD_NS_4 = 1600;
  localparam int unsigned PERIOD_NS_5 = 800;

  // Half period in core cycles, rounded down and never below one, less one for the counter
  function automatic logic [CNT_W-1:0] half_cycles(input int unsigned period_ns);
    int unsigned n;
    n = (period_ns / 2) / (1_000_000_000 / CORE_HZ);
    if (n < 1) begin
      n = 1;
    end
    return CNT_W'(n - 1);
  endfunction

  // Transfer sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,   // Stopped, activity flag low
    ST_RUN  = 2'b01,   // Shifting words
    ST_LAST = 2'b10    // Start cleared, finishing current word
  } ssr_state_t;
endpackage

// ---- logic/ssr_shift_if.sv ----
// Carrier between the sequencer and the serial clock engine
interface ssr_shift_if;
  import ssr_pkg::*;
  logic       run;        // Serial clock may run
  logic       hold;       // Automatic wait request
  logic [2:0] rate;       // Clock rate / external select
  logic       lead;       // Leading (falling) edge pulse
  logic       trail;      // Trailing (rising) edge pulse
  logic       si;         // Synchronised serial input
  logic       sck_out;    // Internal serial clock level
  logic       sck_oe;     // Serial clock pin drive enable

  modport eng  (input run, hold, rate, output lead, trail, si, sck_out, sck_oe);
  modport core (output run, hold, rate, input lead, trail, si, sck_out, sck_oe);
endinterface

// ---- logic/ssr_clk_engine.sv ----
// Serial clock engine: internal divider with wait, or external edge finder
module ssr_clk_engine
  import ssr_pkg::*;
(
  input  wire logic    i_core_clk,   // Core clock
  input  wire logic    i_rst_n,      // Synchronous reset, active low
  input  wire logic    i_sck,        // Serial clock pin input
  input  wire logic    i_si,         // Serial data pin input
  ssr_shift_if.eng     sif           // Engine side of the carrier
);
  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [1:0] sck_sync_reg;          // Two stages for the clock pin
  logic [1:0] si_sync_reg;           // Two stages for the data pin
  logic       sck_prev_reg;          // Last synchronised clock level
  logic       sck_reg;               // Internal clock level, idles high
  logic [CNT_W-1:0] cnt_reg;         // Half period counter
  logic       lead_reg;              // Leading edge pulse
  logic       trail_reg;             // Trailing edge pulse
  logic       sck_oe_reg;            // Clock pin drive enable, registered

  wire logic ext_sel = (sif.rate == RATE_EXT);           // External clock chosen
  wire logic [CNT_W-1:0] half_max =
      (sif.rate == 3'h1) ? half_cycles(PERIOD_NS_1) :
      (sif.rate == 3'h2) ? half_cycles(PERIOD_NS_2) :
      (sif.rate == 3'h3) ? half_cycles(PERIOD_NS_3) :
      (sif.rate == 3'h4) ? half_cycles(PERIOD_NS_4) :
      (sif.rate == 3'h5) ? half_cycles(PERIOD_NS_5) :
                           half_cycles(PERIOD_NS_0);     // 0 and unused 6
  // Wait only stops the clock while it sits high between bits
  wire logic int_go   = sif.run && !ext_sel && !(sck_reg && sif.hold);
  wire logic int_tick = int_go && (cnt_reg == half_max);
  wire logic ext_fall = sif.run && ext_sel && sck_prev_reg && !sck_sync_reg[1];
  wire logic ext_rise = sif.run && ext_sel && !sck_prev_reg && sck_sync_reg[1];

  // Synchronisers: first stage feeds only the second
  always_ff @(posedge i_core_clk) begin
    sck_sync_reg <= {sck_sync_reg[0], i_sck};
    si_sync_reg  <= {si_sync_reg[0], i_si};
    sck_prev_reg <= sck_sync_reg[1];
  end

  // ==========================================================================
  // Internal divider and edge pulses
  // ==========================================================================
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !int_go) begin
      cnt_reg <= '0;
    end else if (int_tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !sif.run) begin
      sck_reg   <= 1'b1;             // Pin high from start of transfer
      lead_reg  <= 1'b0;
      trail_reg <= 1'b0;
    end else begin
      if (int_tick) begin
        sck_reg <= !sck_reg;
      end
      lead_reg  <= (int_tick && sck_reg) || ext_fall;
      trail_reg <= (int_tick && !sck_reg) || ext_rise;
    end
  end

  // Pin enable from a flop; one cycle late after a rate change is harmless
  // because both clock sources idle high
  always_ff @(posedge i_core_clk) begin
    sck_oe_reg <= !ext_sel;
  end

  assign sif.lead    = lead_reg;
  assign sif.trail   = trail_reg;
  assign sif.si      = si_sync_reg[1];
  assign sif.sck_out = sck_reg;
  assign sif.sck_oe  = sck_oe_reg;   // Drive pin unless clock comes from peer
endmodule

// ---- logic/ssr_top.sv ----
// Synchronous serial receive and full-duplex transfer block
// What this block does
// - Receive words of four or eight bits
// - Start bit shifts input, stores each word
// - Pulse interrupt when word count reached
// - Internal clock waits while buffer unread
// - Any buffer read releases the wait
// - External clock overrun abandons reception
// - Clearing start finishes current word, drops active
// - Abort ends reception at once
// - Mode switch discards buffer contents
// - Drive on leading, sample on trailing edge
// - Duplex stores words, interrupts after count
// - Internal clock duplex waits until written
// - Clearing start in duplex finishes word
// - Abort ends duplex at once
// - Words shift least significant bit first
// - Four-bit words store zero upper half
// - Word count selects one to eight words
module ssr_top
  import ssr_pkg::*;
(
  input  wire logic              i_core_clk,     // Core clock, 10 MHz
  input  wire logic              i_rst_n,        // Synchronous reset, active low
  input  wire logic              i_sck,          // Serial clock pin input
  output logic                   o_sck,          // Serial clock pin output
  output logic                   o_sck_oe,       // Serial clock pin drive enable
  input  wire logic              i_si,           // Serial data input pin
  output logic                   o_so,           // Serial data output pin
  input  wire logic              i_mode,         // MODE_RX or MODE_DUPLEX
  input  wire logic              i_word8,        // 1: 8-bit words, 0: 4-bit
  input  wire logic [2:0]        i_rate,         // Clock rate, 7 external
  input  wire logic [IDX_W-1:0]  i_word_count,   // Words per burst minus one
  input  wire logic              i_transfer_start_bit, // Start control bit
  input  wire logic              i_transfer_abort_bit, // Abort control bit
  input  wire logic              i_buf_wr,       // Buffer word write strobe
  input  wire logic              i_buf_rd,       // Buffer word read strobe
  input  wire logic [IDX_W-1:0]  i_buf_addr,     // Buffer word index
  input  wire logic [DATA_W-1:0] i_buf_wdata,    // Buffer write data
  output logic [DATA_W-1:0]      o_buf_rdata,    // Buffer read data
  output logic                   o_transfer_active_flag, // Transfer in process
  output logic                   o_serial_irq    // Burst complete pulse
);
  // ==========================================================================
  // Storage and state
  // ==========================================================================
  ssr_shift_if sif ();                           // Link to clock engine

  logic [DATA_W-1:0] data_buffer_words [BUF_WORDS]; // Buffer bank
  ssr_state_t        state_reg;                  // Sequencer state
  ssr_state_t        state_next;                 // Next sequencer state
  logic [BIT_W-1:0]  bit_reg;                    // Bit within current word
  logic [IDX_W-1:0]  idx_reg;                    // Current buffer word
  logic [DATA_W-1:0] shift_reg;                  // Receive shift register
  logic              pend_reg;                   // Burst done, not yet serviced
  logic              mode_prev_reg;              // Mode seen last cycle
  logic              so_reg;                     // Serial output level
  logic              irq_reg;                    // Interrupt pulse
  logic [DATA_W-1:0] rdata_reg;                  // Read data holding
  logic              active_reg;                 // Activity flag

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire logic duplex    = (i_mode == MODE_DUPLEX);
  wire logic ext_clk   = (i_rate == RATE_EXT);
  wire logic running   = (state_reg != ST_IDLE);
  // Duplex always carries 8-bit words
  wire logic [BIT_W-1:0] last_bit = (i_word8 || duplex) ? LAST_BIT_8 : LAST_BIT_4;
  wire logic word_done = running && sif.trail && (bit_reg == last_bit);
  wire logic burst_end = word_done && (idx_reg == i_word_count);
  wire logic mode_chg  = (i_mode != mode_prev_reg);
  // Received word, LSB first; 4-bit words fill low nibble only
  wire logic [DATA_W-1:0] rx_word = (last_bit == LAST_BIT_8) ?
      {sif.si, shift_reg[DATA_W-1:1]} :
      {NIBBLE_ZERO, sif.si, shift_reg[DATA_W-1:DATA_W-3]};
  // External receive overrun: new burst would overwrite unread words
  wire logic overrun   = word_done && ext_clk && !duplex && pend_reg
                         && (idx_reg == IDX_FIRST);
  wire logic store     = word_done && !overrun;
  // Serviced by a read (receive) or a write (duplex), any buffer word
  wire logic service   = duplex ? i_buf_wr : i_buf_rd;
  wire logic start_ok  = i_transfer_start_bit && !i_transfer_abort_bit;

  // ==========================================================================
  // Sequencer next state
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_ok && !mode_chg) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!i_transfer_start_bit) begin
          state_next = ST_LAST;
        end
        if (overrun) begin
          state_next = ST_IDLE;
        end
      end
      ST_LAST: begin
        if (word_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (i_transfer_abort_bit) begin
      state_next = ST_IDLE;
    end
  end

  // State, counters and shift register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      bit_reg   <= '0;
      idx_reg   <= IDX_FIRST;
      shift_reg <= WORD_ZERO;
      active_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // Flag from its own flop, same timing as the state register
      active_reg <= (state_next != ST_IDLE);
      if (state_next == ST_IDLE) begin
        // Abort drops any partial word
        bit_reg <= '0;
        idx_reg <= IDX_FIRST;
      end else if (sif.trail) begin
        shift_reg <= {sif.si, shift_reg[DATA_W-1:1]};
        bit_reg   <= word_done ? '0 : bit_reg + BIT_ONE;
        if (word_done) begin
          idx_reg <= burst_end ? IDX_FIRST : idx_reg + IDX_ONE;
        end
      end
    end
  end

  // ==========================================================================
  // Buffer bank: mode clear, then hardware store, then software write
  // ==========================================================================
  always_ff @(posedge i_core_clk) begin
    for (int i = 0; i < BUF_WORDS; i++) begin
      if (!i_rst_n || mode_chg) begin
        data_buffer_words[i] <= WORD_ZERO;
      end else if (store && (idx_reg == IDX_W'(i))) begin
        data_buffer_words[i] <= rx_word;
      end else if (i_buf_wr && (i_buf_addr == IDX_W'(i))) begin
        data_buffer_words[i] <= i_buf_wdata;
      end
    end
  end

  // ==========================================================================
  // Wait flag, interrupt, outputs
  // ==========================================================================
  // Set wins over a service in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !running) begin
      pend_reg <= 1'b0;
    end else if (burst_end && !overrun) begin
      pend_reg <= 1'b1;
    end else if (service) begin
      pend_reg <= 1'b0;
    end
  end

  // Wait holds the clock high before the first bit of the next burst
  assign sif.hold = pend_reg && (bit_reg == '0) && (idx_reg == IDX_FIRST);
  assign sif.run  = running;
  assign sif.rate = i_rate;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      mode_prev_reg <= MODE_RX;
      so_reg        <= 1'b1;
      irq_reg       <= 1'b0;
      rdata_reg     <= WORD_ZERO;
    end else begin
      mode_prev_reg <= i_mode;
      irq_reg       <= burst_end && !overrun;
      if (i_buf_rd) begin
        rdata_reg <= data_buffer_words[i_buf_addr];
      end
      // Transmit bit leaves on the leading edge, LSB first
      if (!duplex || !running) begin
        so_reg <= 1'b1;
      end else if (sif.lead) begin
        so_reg <= data_buffer_words[idx_reg][bit_reg];
      end
    end
  end

  assign o_so                   = so_reg;
  assign o_serial_irq           = irq_reg;
  assign o_buf_rdata            = rdata_reg;
  assign o_transfer_active_flag = active_reg;
  assign o_sck                  = sif.sck_out;
  assign o_sck_oe               = sif.sck_oe;

  // Serial clock engine
  ssr_clk_engine ssr_clk_engine_i (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_sck      (i_sck),
    .i_si       (i_si),
    .sif        (sif)
  );
endmodule

// ---- sim/ssr_chk.sv ----
// Port-level checker for the serial receive/duplex block
module ssr_chk
  import ssr_pkg::*;
(
  input wire logic              i_core_clk,
  input wire logic              i_rst_n,
  input wire logic              i_sck,
  input wire logic              o_sck,
  input wire logic              o_sck_oe,
  input wire logic              i_si,
  input wire logic              o_so,
  input wire logic              i_mode,
  input wire logic              i_word8,
  input wire logic [2:0]        i_rate,
  input wire logic [IDX_W-1:0]  i_word_count,
  input wire logic              i_transfer_start_bit,
  input wire logic              i_transfer_abort_bit,
  input wire logic              i_buf_wr,
  input wire logic              i_buf_rd,
  input wire logic [IDX_W-1:0]  i_buf_addr,
  input wire logic [DATA_W-1:0] i_buf_wdata,
  input wire logic [DATA_W-1:0] o_buf_rdata,
  input wire logic              o_transfer_active_flag,
  input wire logic              o_serial_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Helper: burst done, software has not serviced it yet
  // ==========================================================
  logic held_reg;  // Internal clock must be parked
  logic svc;       // Read in receive, write in duplex
  assign svc = (i_mode == MODE_RX) ? i_buf_rd : i_buf_wr;
  // Cleared when idle: an aborted burst leaves nothing to wait on
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !o_transfer_active_flag || i_rate == RATE_EXT || svc) begin
      held_reg <= 1'b0;
    end else if (o_serial_irq) begin
      held_reg <= 1'b1;
    end
  end
  // Helper: word 0 last filled by a one-word 4-bit receive burst
  logic nib_reg;   // Any write, 8-bit mode or mode change voids it
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_mode != MODE_RX || i_word8 || i_buf_wr) begin
      nib_reg <= 1'b0;
    end else if (o_serial_irq && i_word_count == IDX_FIRST) begin
      nib_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // Assertions
  // ==========================================================
  AST_RESET: assert property ($rose(i_rst_n) |-> o_sck && o_so && !o_transfer_active_flag
    && !o_serial_irq && o_buf_rdata == WORD_ZERO) else $error("outputs wrong after reset");
  AST_START: assert property (
    (!o_transfer_active_flag && i_transfer_start_bit && !i_transfer_abort_bit && $stable(i_mode))
    |=> o_transfer_active_flag) else $error("start not taken");
  AST_ABORT: assert property (
    o_transfer_active_flag && i_transfer_abort_bit |=> !o_transfer_active_flag) else $error("abort late");
  AST_IRQ_PULSE: assert property (o_serial_irq |=> !o_serial_irq) else $error("irq wider than one cycle");
  AST_HOLD: assert property (held_reg |-> !$fell(o_sck)) else $error("clock ran during wait");
  AST_RELEASE: assert property (
    held_reg && i_buf_rd && i_mode == MODE_RX && i_rate == 3'h5 && i_transfer_start_bit
    && !i_transfer_abort_bit |-> ##[1:12] $fell(o_sck)) else $error("read did not release wait");
  AST_FINISH: assert property (
    $fell(i_transfer_start_bit) && o_transfer_active_flag && !held_reg && i_rate == 3'h5
    |-> ##[1:90] !o_transfer_active_flag) else $error("stop did not finish word");
  AST_SO_LEAD: assert property (
    $changed(o_so) && i_mode == MODE_DUPLEX && i_rate != RATE_EXT && o_transfer_active_flag
    |-> !o_sck) else $error("output moved outside leading phase");
  AST_SCK_OE: assert property (o_sck_oe == ($past(i_rate) != RATE_EXT)) else $error("clock drive enable wrong");
  AST_NIBBLE_ZERO: assert property (
    nib_reg && i_buf_rd && i_buf_addr == IDX_FIRST |=> o_buf_rdata[7:4] == NIBBLE_ZERO)
    else $error("upper half of 4-bit word not zero");
endmodule

// ---- sim/ssr_peer.sv ----
// Behavioural serial peer: shifts a bit pattern in, captures output
module ssr_peer (
  input  wire logic i_clk,  // Core clock, for idle detection
  input  wire logic i_sck,  // Resolved serial clock wire
  input  wire logic i_so,   // Device serial output
  output logic      o_sck,  // Peer clock, idles high
  output logic      o_si    // Data toward device
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] pattern;  // Bits to send, bit 0 first
  logic [63:0] rx_bits;  // Captured device output
  int          tx_ptr;   // Next bit to send
  int          rx_ptr;   // Next capture slot
  logic        bit_q;    // Bit on the line
  logic        last_sck; // Clock seen last cycle
  logic [7:0]  idle;     // Cycles without a clock edge
  initial begin
    o_sck = 1'b1;
    pattern = '0;
    rx_bits = '0;
    tx_ptr = 0;
    rx_ptr = 0;
    bit_q = 1'b1;
    last_sck = 1'b1;
    idle = 8'h00;
  end
  task automatic load(input logic [63:0] p);
    pattern = p;
    tx_ptr = 0;
    rx_ptr = 0;
    rx_bits = '0;
  endtask
  // Odd offset keeps the link phase unrelated to the core clock
  task automatic ext_burst(input int n);
    #37;
    repeat (n) begin
      #400 o_sck = 1'b0;
      #400 o_sck = 1'b1;
    end
  endtask
  // Drive on leading edge, LSB first
  always @(negedge i_sck) begin
    bit_q <= pattern[tx_ptr];
    tx_ptr <= tx_ptr + 1;
  end
  // Capture on trailing edge
  always @(posedge i_sck) begin
    rx_bits[rx_ptr] <= i_so;
    rx_ptr <= rx_ptr + 1;
  end
  // Hold time over: line shows the inverse, never a stale bit
  always @(posedge i_clk) begin
    last_sck <= i_sck;
    idle <= (i_sck != last_sck) ? 8'h00 : idle + {7'h00, idle != 8'hFF};
  end
  assign o_si = (idle > 8'h0C) ? ~bit_q : bit_q;
endmodule

// ---- sim/ssr_top_bench.sv ----
// Self-checking bench for the serial receive/duplex block
module ssr_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ssr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, mode = MODE_RX, word8 = 1'b1, start = 1'b0, abort = 1'b0;
  logic wr = 1'b0, rd = 1'b0;
  logic [2:0] rate = 3'h5, cnt = 3'h0, addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, d;
  logic sck, sck_oe, so, si, act, irq, peer_sck, sck_pin;
  int err_total = 0, check_count = 0, cycles = 0;
  always #50 clk = ~clk;
  // Clock wire: device drives unless external source selected
  assign sck_pin = sck_oe ? sck : peer_sck;
  ssr_top ssr_top_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_sck(sck_pin), .o_sck(sck), .o_sck_oe(sck_oe),
    .i_si(si), .o_so(so), .i_mode(mode), .i_word8(word8), .i_rate(rate), .i_word_count(cnt),
    .i_transfer_start_bit(start), .i_transfer_abort_bit(abort), .i_buf_wr(wr), .i_buf_rd(rd),
    .i_buf_addr(addr), .i_buf_wdata(wdata), .o_buf_rdata(rdata), .o_transfer_active_flag(act),
    .o_serial_irq(irq));
  ssr_peer ssr_peer_i (.i_clk(clk), .i_sck(sck_pin), .i_so(so), .o_sck(peer_sck), .o_si(si));
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic results();
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic buf_read(input logic [2:0] a, output logic [7:0] v);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic buf_write(input logic [2:0] a, input logic [7:0] v);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = v;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Selector: 0 activity flag, 1 irq, 2 serial clock; bounded wait
  task automatic wait_for(input int sel, input logic v);
    int n;
    n = 0;
    while (((sel == 0) ? act : (sel == 1) ? irq : sck) !== v && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n == 3000) begin
      err_total++;
    end
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    // Internal 8-bit receive, a two-word burst then a one-word burst
    ssr_peer_i.load(64'h0000_0000_00E1_3C96);
    cnt = 3'h1;
    start = 1'b1;
    wait_for(1, 1'b1);
    repeat (30) @(negedge clk);
    check("clock parked", {7'h00, sck}, 8'h01);
    cnt = 3'h0;
    buf_read(3'h7, d);
    buf_read(3'h0, d);
    check("word 0", d, 8'h96);
    buf_read(3'h1, d);
    check("word 1", d, 8'h3C);
    wait_for(2, 1'b0);
    start = 1'b0;
    wait_for(0, 1'b0);
    buf_read(3'h0, d);
    check("final word", d, 8'hE1);
    // 4-bit receive, abort while parked, then mode switch
    ssr_peer_i.load(64'hFFFF_FFFF_FFFF_FFF5);
    cnt = 3'h0;
    word8 = 1'b0;
    start = 1'b1;
    wait_for(1, 1'b1);
    @(negedge clk);
    abort = 1'b1;
    @(negedge clk);
    check("abort flag", {7'h00, act}, 8'h00);
    abort = 1'b0;
    start = 1'b0;
    buf_read(3'h0, d);
    check("nibble word", d, 8'h05);
    mode = MODE_DUPLEX;
    buf_read(3'h0, d);
    check("buffer after switch", d, 8'h00);
    // Internal duplex, a one-word burst, then a two-word burst stopped after one word
    buf_write(3'h0, 8'h5A);
    ssr_peer_i.load(64'h0000_0000_0000_7EC5);
    start = 1'b1;
    wait_for(1, 1'b1);
    cnt = 3'h1;
    buf_read(3'h0, d);
    check("duplex rx 0", d, 8'hC5);
    check("duplex tx 0", ssr_peer_i.rx_bits[7:0], 8'h5A);
    buf_write(3'h0, 8'h81);
    wait_for(2, 1'b0);
    start = 1'b0;
    wait_for(0, 1'b0);
    buf_read(3'h0, d);
    check("duplex rx 1", d, 8'h7E);
    check("duplex tx 1", ssr_peer_i.rx_bits[15:8], 8'h81);
    // External receive, first burst unserviced, second burst overruns
    mode = MODE_RX;
    word8 = 1'b1;
    rate = RATE_EXT;
    cnt = 3'h0;
    ssr_peer_i.load(64'h0000_0000_0000_4DB2);
    repeat (2) @(negedge clk);
    start = 1'b1;
    repeat (4) @(negedge clk);
    ssr_peer_i.ext_burst(8);
    wait_for(1, 1'b1);
    ssr_peer_i.ext_burst(8);
    wait_for(0, 1'b0);
    start = 1'b0;
    check("overrun flag", {7'h00, act}, 8'h00);
    buf_read(3'h0, d);
    check("overrun kept", d, 8'hB2);
    // External duplex, software keeps ahead of the peer
    mode = MODE_DUPLEX;
    buf_write(3'h0, 8'hC3);
    ssr_peer_i.load(64'h0000_0000_0000_1EA5);
    start = 1'b1;
    repeat (4) @(negedge clk);
    ssr_peer_i.ext_burst(8);
    wait_for(1, 1'b1);
    buf_read(3'h0, d);
    check("ext duplex rx 0", d, 8'hA5);
    check("ext duplex tx 0", ssr_peer_i.rx_bits[7:0], 8'hC3);
    buf_write(3'h0, 8'h3C);
    start = 1'b0;
    ssr_peer_i.ext_burst(8);
    wait_for(0, 1'b0);
    buf_read(3'h0, d);
    check("ext duplex rx 1", d, 8'h1E);
    check("ext duplex tx 1", ssr_peer_i.rx_bits[15:8], 8'h3C);
    results();
  end
endmodule
bind ssr_top ssr_chk ssr_chk_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sck(i_sck), .o_sck(o_sck),
  .o_sck_oe(o_sck_oe), .i_si(i_si), .o_so(o_so), .i_mode(i_mode), .i_word8(i_word8), .i_rate(i_rate),
  .i_word_count(i_word_count), .i_transfer_start_bit(i_transfer_start_bit),
  .i_transfer_abort_bit(i_transfer_abort_bit), .i_buf_wr(i_buf_wr), .i_buf_rd(i_buf_rd),
  .i_buf_addr(i_buf_addr), .i_buf_wdata(i_buf_wdata), .o_buf_rdata(o_buf_rdata),
  .o_transfer_active_flag(o_transfer_active_flag), .o_serial_irq(o_serial_irq));
